// [tb/nsf_host_model.sv]
`timescale 1ns/1ps

module nsf_host_model
(
  // serial link toward the device
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  // device reply
  input wire logic miso_o,
  input wire logic miso_oe_n
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b0;
    mosi = 1'b0;
    // a real rising select clears the link-side counters before use
    #5 cs_n = 1'b1;
  end
  // ------------------------------------------
  // one frame, msb first; clock stands low outside frames
  // ------------------------------------------
  task automatic frame(input logic [31:0] tx, input int nb,
    output logic [7:0] rx);
    int i;
    // lead-in gap keeps cs_n high well over 6 system cycles
    #101.3;
    cs_n = 1'b0;
    for (i = 0; i < nb; i++)
    begin
      mosi = tx[31 - i];
      #32 sclk = 1'b1;
      if (i >= 16 && i < 24)
        rx = {rx[6:0], miso_oe_n ? 1'bx : miso_o};
      #32 sclk = 1'b0;
    end
    #17.9 cs_n = 1'b1;
    mosi = ~mosi;
  endtask
endmodule

// [tb/nsf_status_flags_sva.sv]
`timescale 1ns/1ps

module nsf_status_flags_sva
  import nsf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe_n,
  // array engine
  input wire logic op_start,
  input wire logic op_abort,
  input wire nsf_op_e op_kind,
  input wire logic [23:0] op_addr,
  input wire logic op_done,
  input wire logic op_fail,
  input wire logic [1:0] op_ecc,
  input wire logic [7:0] op_spare0,
  // status view
  input wire logic [7:0] operation_status,
  input wire logic bad_block_seen,
  input wire logic bbm_mark_match
);
  // ------------------------------------------
  // helper state
  // ------------------------------------------
  logic abort_ff;
  logic fail_ff;
  logic [1:0] ecc_ff;
  logic [7:0] spare_ff;
  // results of an aborted op are dropped, so they must not count
  wire done_ok = op_done && !abort_ff;

  always_ff @(posedge clk)
  begin
    if (!rst_n || op_done)
      abort_ff <= 1'b0;
    else if (op_abort)
      abort_ff <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (op_done)
    begin
      fail_ff <= op_fail;
      ecc_ff <= op_ecc;
      spare_ff <= op_spare0;
    end
  end

  // ------------------------------------------
  // properties
  // ------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_run;
    op_start ##1 !op_done [*5];
  endsequence
  sequence s_stop;
    op_abort ##1 !op_done [*5];
  endsequence

  property p_busy_run;
    s_run |-> operation_status[0];
  endproperty
  a_busy_run: assert property (p_busy_run) else $error("busy low");
  property p_busy_end;
    done_ok |-> ##[1:6] !operation_status[0];
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy stuck");
  property p_abort_hold;
    s_stop |-> operation_status[0];
  endproperty
  a_abort_hold: assert property (p_abort_hold) else $error("abort");
  property p_reboot;
    op_done && abort_ff |-> ##[1:4] op_start && op_kind == NSF_OP_BOOTLOAD;
  endproperty
  a_reboot: assert property (p_reboot) else $error("no reload");
  property p_wel_gate;
    op_start && op_kind inside {NSF_OP_COMMIT, NSF_OP_WIPE}
      |-> operation_status[1];
  endproperty
  a_wel_gate: assert property (p_wel_gate) else $error("latch");
  property p_pfail;
    done_ok && op_kind == NSF_OP_COMMIT |-> ##6 operation_status[3] == fail_ff;
  endproperty
  a_pfail: assert property (p_pfail) else $error("pfail");
  property p_efail;
    done_ok && op_kind == NSF_OP_WIPE |-> ##6 operation_status[2] == fail_ff;
  endproperty
  a_efail: assert property (p_efail) else $error("efail");
  property p_ecc;
    done_ok && op_kind inside {NSF_OP_READ, NSF_OP_BOOTLOAD}
      |-> ##6 operation_status[5:4] == ecc_ff;
  endproperty
  a_ecc: assert property (p_ecc) else $error("ecc");
  property p_bbm;
    done_ok && op_kind == NSF_OP_READ |-> ##[1:3] bbm_mark_match ==
      (spare_ff == 8'h00) && bad_block_seen == (spare_ff != 8'hFF);
  endproperty
  a_bbm: assert property (p_bbm) else $error("bad block");
endmodule

bind nsf_status_flags nsf_status_flags_sva u_nsf_status_flags_sva
(
  .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
  .miso_o(miso_o), .miso_oe_n(miso_oe_n), .op_start(op_start),
  .op_abort(op_abort), .op_kind(op_kind), .op_addr(op_addr),
  .op_done(op_done), .op_fail(op_fail), .op_ecc(op_ecc),
  .op_spare0(op_spare0), .operation_status(operation_status),
  .bad_block_seen(bad_block_seen), .bbm_mark_match(bbm_mark_match)
);

// [tb/tb.sv]
`timescale 1ns/1ps
`include "nsf_regs.svh"

module tb;
  import nsf_pkg::*;
  // ------------------------------------------
  // signals and reference state
  // ------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b1;
  logic op_done = 1'b0;
  logic op_fail = 1'b0;
  logic [1:0] op_ecc = 2'h0;
  logic [7:0] op_spare0 = 8'hFF;
  logic [7:0] rx, s, operation_status;
  logic sclk, cs_n, mosi, miso_o, miso_oe_n, op_start, op_abort;
  logic bad_block_seen, bbm_mark_match;
  logic [23:0] op_addr, a;
  nsf_op_e op_kind;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0, n_start = 0, n_abort = 0, i, e, f;
  int write_enable_latch = 0, pf = 0, ef = 0, ecc = 0;

  nsf_host_model u_nsf_host_model
  (
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso_o(miso_o), .miso_oe_n(miso_oe_n)
  );
  nsf_status_flags u_nsf_status_flags
  (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso_o(miso_o), .miso_oe_n(miso_oe_n), .op_start(op_start),
    .op_abort(op_abort), .op_kind(op_kind), .op_addr(op_addr),
    .op_done(op_done), .op_fail(op_fail), .op_ecc(op_ecc),
    .op_spare0(op_spare0), .operation_status(operation_status),
    .bad_block_seen(bad_block_seen), .bbm_mark_match(bbm_mark_match)
  );

  always #4 clk = ~clk;

  // run needs about 11k cycles; ceiling leaves ample margin
  always @(negedge clk)
  begin
    cyc++;
    if (op_start === 1'b1)
      n_start++;
    if (op_abort === 1'b1)
      n_abort++;
    if (cyc == 50000)
    begin
      n_mismatch++;
      final_report;
    end
  end

  // ------------------------------------------
  // tasks
  // ------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] ex,
    input logic [23:0] got);
    n_checks++;
    if (got !== ex)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic send(input logic [31:0] tx, input int nb);
    u_nsf_host_model.frame(tx, nb, rx);
  endtask

  task automatic rd(input int b);
    send({`NSF_CMD_GETF, `NSF_FADDR_STATUS, 16'h0000}, 24);
    chk("status", {18'h0, ecc[1:0], pf[0], ef[0], write_enable_latch[0], b[0]}, rx);
  endtask

  task automatic wstart(input nsf_op_e k);
    int j;
    for (j = 0; j < 60 && op_start !== 1'b1; j++)
      @(negedge clk);
    chk("op_start", 24'h1, op_start);
    chk("op_kind", k, op_kind);
  endtask

  // engine answer; values outside the pulse are deliberately wrong
  task automatic done(input logic fl, input logic [1:0] ec,
    input logic [7:0] sp);
    repeat (6 + $urandom_range(0, 20)) @(negedge clk);
    op_fail = fl;
    op_ecc = ec;
    op_spare0 = sp;
    op_done = 1'b1;
    @(negedge clk);
    op_done = 1'b0;
    op_fail = ~fl;
    op_ecc = ~ec;
    op_spare0 = ~sp;
  endtask

  // ------------------------------------------
  // main sequence
  // ------------------------------------------
  initial
  begin
    void'($urandom(32'h3078));
    // a real falling edge also clears the link-side sequence toggle
    @(negedge clk);
    rst_n = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    wstart(NSF_OP_BOOTLOAD);
    chk("boot addr", 24'h0, op_addr);
    rd(1);
    ecc = $urandom_range(0, 3);
    done(1'b0, ecc[1:0], 8'hFF);
    rd(0);
    send({`NSF_CMD_COMMIT, 24'h000040}, 32);
    rd(0);
    chk("starts", 24'h1, 24'(n_start));
    for (i = 0; i < 6; i++)
    begin
      f = (i != 1) && (i != 4);
      a = 24'($urandom);
      send({`NSF_CMD_WREN, 24'h0}, 8);
      write_enable_latch = 1;
      if (i == 0)
      begin
        send({`NSF_CMD_WRDI, 24'h0}, 8);
        write_enable_latch = 0;
        rd(0);
        send({`NSF_CMD_WREN, 24'h0}, 8);
        write_enable_latch = 1;
      end
      send({i < 3 ? `NSF_CMD_COMMIT : `NSF_CMD_WIPE, a}, 32);
      wstart(i < 3 ? NSF_OP_COMMIT : NSF_OP_WIPE);
      chk("op_addr", a, op_addr);
      pf = (i < 3) ? 0 : pf;
      ef = (i < 3) ? ef : 0;
      rd(1);
      done(f[0], 2'($urandom), 8'($urandom));
      pf = (i < 3) ? f : pf;
      ef = (i < 3) ? ef : f;
      rd(0);
    end
    send({`NSF_CMD_SETF, `NSF_FADDR_STATUS, 16'hFF00}, 24);
    rd(0);
    send({`NSF_CMD_RESET, 24'h0}, 8);
    pf = 0;
    ef = 0;
    wstart(NSF_OP_BOOTLOAD);
    rd(1);
    ecc = $urandom_range(0, 3);
    done(1'b0, ecc[1:0], 8'hFF);
    rd(0);
    for (i = 0; i < 4; i++)
    begin
      e = (i + 1) % 4;
      s = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      send({`NSF_CMD_PGRD, 24'($urandom)}, 32);
      wstart(NSF_OP_READ);
      ecc = 0;
      rd(1);
      done(1'b0, e[1:0], s);
      ecc = e;
      rd(0);
      chk("mark match", s == 8'h00, bbm_mark_match);
      chk("bad block", s != 8'hFF, bad_block_seen);
    end
    send({`NSF_CMD_PGRD, 24'h0}, 32);
    wstart(NSF_OP_READ);
    ecc = 0;
    send({`NSF_CMD_RESET, 24'h0}, 8);
    rd(1);
    chk("aborts", 24'h1, 24'(n_abort));
    done(1'b1, 2'h2, 8'h00);
    wstart(NSF_OP_BOOTLOAD);
    rd(1);
    ecc = $urandom_range(0, 3);
    done(1'b0, ecc[1:0], 8'hFF);
    rd(0);
    final_report;
  end
endmodule

// [verilog/nsf_pkg.sv]
package nsf_pkg;

  typedef enum logic [1:0]
  {
    NSF_ST_IDLE = 2'b00,
    NSF_ST_BOOT = 2'b01,
    NSF_ST_RUN = 2'b10,
    NSF_ST_ABORT = 2'b11
  } nsf_state_e;

  typedef enum logic [1:0]
  {
    NSF_OP_READ = 2'b00,
    NSF_OP_COMMIT = 2'b01,
    NSF_OP_WIPE = 2'b10,
    NSF_OP_BOOTLOAD = 2'b11
  } nsf_op_e;

endpackage

// [verilog/nsf_regs.svh]
`ifndef NSF_REGS_SVH
`define NSF_REGS_SVH

// ---------------------------------------------------------------
// command opcodes seen on the serial link
// ---------------------------------------------------------------
`define NSF_CMD_WREN 8'h06
`define NSF_CMD_WRDI 8'h04
`define NSF_CMD_GETF 8'h0F
`define NSF_CMD_SETF 8'h1F
`define NSF_CMD_PGRD 8'h13
`define NSF_CMD_COMMIT 8'h10
`define NSF_CMD_WIPE 8'hD8
`define NSF_CMD_RESET 8'hFF

// ---------------------------------------------------------------
// feature address and operation_status layout
// ---------------------------------------------------------------
`define NSF_FADDR_STATUS 8'hC0
`define NSF_BIT_BUSY 0
`define NSF_BIT_WEL 1
`define NSF_BIT_EFAIL 2
`define NSF_BIT_PFAIL 3
`define NSF_ECC_LO 4
`define NSF_ECC_HI 5
`define NSF_STATUS_RST 8'h00
`define NSF_ECC_NONE 2'h0
`define NSF_ECC_FIXED 2'h1
`define NSF_ECC_UNCORR 2'h2
`define NSF_ECC_FIXED8 2'h3

// ---------------------------------------------------------------
// bad-block marking and frame bit positions
// ---------------------------------------------------------------
`define NSF_BBM_MARK 8'h00
`define NSF_BBM_ERASED 8'hFF
`define NSF_CNT_CMD_END 6'h07
`define NSF_CNT_BYTE2_END 6'h0F
`define NSF_CNT_ADDR_BEG 6'h08
`define NSF_CNT_ADDR_END 6'h1F
`define NSF_CNT_MAX 6'h3F

`endif

// [verilog/nsf_status_flags.sv]
`timescale 1ns/1ps
`include "nsf_regs.svh"

module nsf_status_flags
  import nsf_pkg::*;
(
  // system clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso_o,
  output logic miso_oe_n,
  // array engine request
  output logic op_start,
  output logic op_abort,
  output nsf_op_e op_kind,
  output logic [23:0] op_addr,
  // array engine answer
  input wire logic op_done,
  input wire logic op_fail,
  input wire logic [1:0] op_ecc,
  input wire logic [7:0] op_spare0,
  // status view and bad-block report
  output logic [7:0] operation_status,
  output logic bad_block_seen,
  output logic bbm_mark_match
);

  // ---------------------------------------------------------------
  // link side: frame shift and capture
  // ---------------------------------------------------------------
  logic [5:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] cmd_ff;
  logic [23:0] addr_ff;
  logic cmd_seq_ff;
  logic [7:0] cur_byte;
  logic rd_en_ff;
  logic [7:0] tx_ff;
  logic [7:0] copy_ff;
  logic ack_ff;
  logic req_lk;
  logic miso_ff;
  logic miso_oe_n_ff;

  assign cur_byte = {shift_ff[6:0], mosi};

  // counter starts over at every frame; cs_n high holds it clear
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
      bit_cnt_ff <= 6'h00;
    else if (bit_cnt_ff != `NSF_CNT_MAX)
      bit_cnt_ff <= bit_cnt_ff + 6'h01;
  end

  always_ff @(posedge sclk)
  begin
    shift_ff <= cur_byte;
  end

  always_ff @(posedge sclk)
  begin
    if (bit_cnt_ff == `NSF_CNT_CMD_END)
      cmd_ff <= cur_byte;
  end

  always_ff @(posedge sclk)
  begin
    if ((bit_cnt_ff >= `NSF_CNT_ADDR_BEG) &&
        (bit_cnt_ff <= `NSF_CNT_ADDR_END))
      addr_ff <= {addr_ff[22:0], mosi};
  end

  // sequence toggle marks a new command byte; it must survive cs_n
  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
      cmd_seq_ff <= 1'b0;
    else if (bit_cnt_ff == `NSF_CNT_CMD_END)
      cmd_seq_ff <= ~cmd_seq_ff;
  end

  // ---------------------------------------------------------------
  // link side: status copy by four-phase handshake
  // ---------------------------------------------------------------
  logic req_ff;
  logic [7:0] hold_ff;

  nsf_sync2 u_req_sync
  (
    .clk(sclk),
    .clr(cs_n),
    .d(req_ff),
    .q(req_lk)
  );

  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
      ack_ff <= 1'b0;
    else
      ack_ff <= req_lk;
  end

  // hold_ff is steady while req is high, so a word copy is safe
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
      copy_ff <= `NSF_STATUS_RST;
    else if (req_lk && !ack_ff)
      copy_ff <= hold_ff;
  end

  // ---------------------------------------------------------------
  // link side: get-feature reply
  // ---------------------------------------------------------------
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
      rd_en_ff <= 1'b0;
    else if (bit_cnt_ff == `NSF_CNT_BYTE2_END)
      rd_en_ff <= (cmd_ff == `NSF_CMD_GETF) &&
                  (cur_byte == `NSF_FADDR_STATUS);
  end

  // the reply repeats while the host keeps clocking
  always_ff @(posedge sclk)
  begin
    if (bit_cnt_ff == `NSF_CNT_BYTE2_END)
      tx_ff <= copy_ff;
    else if (rd_en_ff)
      tx_ff <= {tx_ff[6:0], tx_ff[7]};
  end

  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      miso_ff <= 1'b0;
      miso_oe_n_ff <= 1'b1;
    end
    else
    begin
      miso_ff <= rd_en_ff ? tx_ff[7] : 1'b0;
      miso_oe_n_ff <= ~rd_en_ff;
    end
  end

  assign miso_o = miso_ff;
  assign miso_oe_n = miso_oe_n_ff;

  // ---------------------------------------------------------------
  // core side: frame end detect and command pickup
  // ---------------------------------------------------------------
  logic cs_q;
  logic ack_q;
  logic cs_prev_ff;
  logic seen_seq_ff;
  logic cmd_evt;

  nsf_sync2 u_cs_sync
  (
    .clk(clk),
    .clr(1'b0),
    .d(cs_n),
    .q(cs_q)
  );

  nsf_sync2 u_ack_sync
  (
    .clk(clk),
    .clr(1'b0),
    .d(ack_ff),
    .q(ack_q)
  );

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cs_prev_ff <= 1'b1;
    else
      cs_prev_ff <= cs_q;
  end

  // cmd_ff and addr_ff are still once the frame has closed
  assign cmd_evt = cs_q && !cs_prev_ff && (cmd_seq_ff != seen_seq_ff);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      seen_seq_ff <= 1'b0;
    else if (cs_q && !cs_prev_ff)
      seen_seq_ff <= cmd_seq_ff;
  end

  // ---------------------------------------------------------------
  // core side: operation sequencer
  // ---------------------------------------------------------------
  nsf_state_e state_ff;
  nsf_state_e nxt_state;
  logic busy_ff;
  logic wel_ff;
  logic pfail_ff;
  logic efail_ff;
  logic [1:0] ecc_ff;
  logic start_ff;
  logic abort_ff;
  nsf_op_e kind_ff;
  logic [23:0] op_addr_ff;
  logic is_rst;
  logic is_read;
  logic is_commit;
  logic is_wipe;
  logic launch;

  assign is_rst = cmd_evt && (cmd_ff == `NSF_CMD_RESET);
  assign is_read = cmd_evt && (cmd_ff == `NSF_CMD_PGRD);
  assign is_commit = cmd_evt && (cmd_ff == `NSF_CMD_COMMIT) && wel_ff;
  assign is_wipe = cmd_evt && (cmd_ff == `NSF_CMD_WIPE) && wel_ff;
  assign launch = (state_ff == NSF_ST_IDLE) &&
                  (is_read || is_commit || is_wipe);

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      NSF_ST_BOOT:
        nxt_state = NSF_ST_RUN;
      NSF_ST_IDLE:
      begin
        if (is_rst)
          nxt_state = NSF_ST_BOOT;
        else if (launch)
          nxt_state = NSF_ST_RUN;
      end
      NSF_ST_RUN:
      begin
        // an operation that ends with the reset command needs no wind-down
        if (is_rst && op_done)
          nxt_state = NSF_ST_BOOT;
        else if (is_rst)
          nxt_state = NSF_ST_ABORT;
        else if (op_done)
          nxt_state = NSF_ST_IDLE;
      end
      NSF_ST_ABORT:
      begin
        if (op_done)
          nxt_state = NSF_ST_BOOT;
      end
      default:
        nxt_state = NSF_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_ff <= NSF_ST_BOOT;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      start_ff <= 1'b0;
      kind_ff <= NSF_OP_BOOTLOAD;
      op_addr_ff <= 24'h000000;
    end
    else if (state_ff == NSF_ST_BOOT)
    begin
      start_ff <= 1'b1;
      kind_ff <= NSF_OP_BOOTLOAD;
      op_addr_ff <= 24'h000000;
    end
    else if (launch && !is_rst)
    begin
      start_ff <= 1'b1;
      op_addr_ff <= addr_ff;
      if (is_read)
        kind_ff <= NSF_OP_READ;
      else if (is_commit)
        kind_ff <= NSF_OP_COMMIT;
      else
        kind_ff <= NSF_OP_WIPE;
    end
    else
      start_ff <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      abort_ff <= 1'b0;
    else
      abort_ff <= (state_ff == NSF_ST_RUN) && is_rst && !op_done;
  end

  // busy covers boot load, operations and the wind-down of an abort
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      busy_ff <= 1'b1;
    else
      busy_ff <= (nxt_state != NSF_ST_IDLE);
  end

  // ---------------------------------------------------------------
  // core side: status flags
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      wel_ff <= 1'b0;
    else if (cmd_evt && (cmd_ff == `NSF_CMD_WREN))
      wel_ff <= 1'b1;
    else if (cmd_evt && (cmd_ff == `NSF_CMD_WRDI))
      wel_ff <= 1'b0;
  end

  // engine reports invalid, OTP-locked or protected targets as op_fail
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pfail_ff <= 1'b0;
    // a result landing with a reset command wins over the clear
    else if ((state_ff == NSF_ST_RUN) && op_done &&
             (kind_ff == NSF_OP_COMMIT))
      pfail_ff <= op_fail;
    else if (is_rst || (launch && is_commit))
      pfail_ff <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      efail_ff <= 1'b0;
    else if ((state_ff == NSF_ST_RUN) && op_done &&
             (kind_ff == NSF_OP_WIPE))
      efail_ff <= op_fail;
    else if (is_rst || (launch && is_wipe))
      efail_ff <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ecc_ff <= `NSF_ECC_NONE;
    else if (launch && is_read)
      ecc_ff <= `NSF_ECC_NONE;
    else if ((state_ff == NSF_ST_RUN) && op_done &&
             ((kind_ff == NSF_OP_READ) || (kind_ff == NSF_OP_BOOTLOAD)))
      ecc_ff <= op_ecc;
  end

  // ---------------------------------------------------------------
  // core side: status word and publication to the link
  // ---------------------------------------------------------------
  logic [7:0] status_w;
  logic [7:0] status_ff;

  // no write path exists: set-feature to this address changes nothing
  always_comb
  begin
    status_w = `NSF_STATUS_RST;
    status_w[`NSF_ECC_HI:`NSF_ECC_LO] = ecc_ff;
    status_w[`NSF_BIT_PFAIL] = pfail_ff;
    status_w[`NSF_BIT_EFAIL] = efail_ff;
    status_w[`NSF_BIT_WEL] = wel_ff;
    status_w[`NSF_BIT_BUSY] = busy_ff;
  end

  // hold_ff only moves when a handshake completes, so the core view has its own copy
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      status_ff <= `NSF_STATUS_RST;
    else
      status_ff <= status_w;
  end

  // republish after every completed handshake; the link picks up a fresh copy per frame
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      req_ff <= 1'b0;
      hold_ff <= `NSF_STATUS_RST;
    end
    else if (!req_ff && !ack_q)
    begin
      req_ff <= 1'b1;
      hold_ff <= status_w;
    end
    else if (req_ff && ack_q)
      req_ff <= 1'b0;
  end

  // ---------------------------------------------------------------
  // core side: bad-block mark check on page reads
  // ---------------------------------------------------------------
  logic bad_ff;
  logic mark_ff;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bad_ff <= 1'b0;
      mark_ff <= 1'b0;
    end
    else if ((state_ff == NSF_ST_RUN) && op_done &&
             (kind_ff == NSF_OP_READ))
    begin
      bad_ff <= (op_spare0 != `NSF_BBM_ERASED);
      mark_ff <= (op_spare0 == `NSF_BBM_MARK);
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign op_start = start_ff;
  assign op_abort = abort_ff;
  assign op_kind = kind_ff;
  assign op_addr = op_addr_ff;
  assign operation_status = status_ff;
  assign bad_block_seen = bad_ff;
  assign bbm_mark_match = mark_ff;

endmodule

// [verilog/nsf_sync2.sv]
`timescale 1ns/1ps

module nsf_sync2
(
  // clock and asynchronous clear
  input wire logic clk,
  input wire logic clr,
  // level in and out
  input wire logic d,
  output logic q
);

  logic meta_ff;
  logic q_ff;

  always_ff @(posedge clk or posedge clr)
  begin
    if (clr)
    begin
      meta_ff <= 1'b0;
      q_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule
